// File: rtl/adc_params.svh
// constants for the aux converter 2 and timing-error register slice
// assumes inclusion by the one design file only; the package does not include it
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
`define ADC_OFS_DAC2_LOW 5'h11
`define ADC_OFS_DAC2_CTRL 5'h12
`define ADC_OFS_RSV_FIRST 5'h13
`define ADC_OFS_RSV_LAST 5'h18
`define ADC_OFS_IRQ 5'h19
`define ADC_OFS_REV 5'h1F
`define ADC_RST_BYTE 8'h00
`define ADC_BIT_LEG 7
`define ADC_BIT_DIR 6
`define ADC_BIT_PD 5
`define ADC_MSB_HI 1
`define ADC_BIT_DERR 7
`define ADC_BIT_SERR 6
`define ADC_BIT_ETYPE 4
`define ADC_BIT_DEN 3
`define ADC_BIT_SEN 2
`define ADC_BIT_LOOP 0
`endif

// File: rtl/adc_pkg.sv
// types shared by the register slice
// assumes adc_params.svh is on the include path
package adc_pkg;
    // register access strobe group from the serial control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [7:0] wdata;
    } adc_req_t;
    // analog-facing controls of aux converter 2
    typedef struct packed {
        logic [9:0] level;
        logic neg_leg;
        logic sink;
        logic power_down;
    } adc_aux_t;
endpackage

// File: rtl/adc_regs.sv
// register slice: aux converter 2 controls, timing-error flags, revision
// assumes the serial port decoder gives one-cycle rd/wr strobes on clk_sys
// Function
// - level word from upper bits 1:0, lower byte
// - magnitude rises monotonic with level word
// - bit7 selects leg, bit6 selects direction
// - bit5 one powers converter down
// - data timing flag latched, cleared by read
// - sync timing flag latched, cleared by read
// - bit4 reports hold or setup error
// - bit3 enables data timing interrupt
// - bit2 enables sync timing interrupt
// - bit0 loops sync output to input
// - fixed revision byte, writes ignored
`timescale 1ns/10ps
`include "adc_params.svh"
module adc_regs
    import adc_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'hA5 // arbitrary value
)(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire adc_req_t req,
    output logic [7:0] rdata,
    input wire logic data_timing_err,
    input wire logic data_err_is_setup,
    input wire logic sync_timing_err,
    input wire logic sync_out,
    input wire logic sync_in_pin,
    output logic sync_in_path,
    output adc_aux_t aux2,
    output logic aux2_positive_output,
    output logic aux2_negative_output,
    output logic irq
);
    logic [7:0] dac_low;
    logic [7:0] dac_ctrl;
    logic derr, serr, etype, den, sen, loopen;
    logic [7:0] next_dac_low;
    logic [7:0] next_dac_ctrl;
    logic next_derr, next_serr, next_etype, next_den, next_sen, next_loopen;
    logic [7:0] next_rdata;
    logic rd_irq;

    assign rd_irq = req.rd && (req.addr == `ADC_OFS_IRQ);

    // next values; a new error wins over the read that clears
    always_comb
    begin
        next_dac_low = dac_low;
        next_dac_ctrl = dac_ctrl;
        next_den = den;
        next_sen = sen;
        next_loopen = loopen;
        if (req.wr && req.addr == `ADC_OFS_DAC2_LOW)
            next_dac_low = req.wdata;
        if (req.wr && req.addr == `ADC_OFS_DAC2_CTRL)
            next_dac_ctrl = req.wdata;
        if (req.wr && req.addr == `ADC_OFS_IRQ)
        begin
            next_den = req.wdata[`ADC_BIT_DEN];
            next_sen = req.wdata[`ADC_BIT_SEN];
            next_loopen = req.wdata[`ADC_BIT_LOOP];
        end
        next_derr = data_timing_err | (derr & ~rd_irq);
        next_serr = sync_timing_err | (serr & ~rd_irq);
        // type taken from the latest data timing error, even while the flag is already set
        next_etype = data_timing_err ? data_err_is_setup : etype;
        // read data; revision register has no write path
        next_rdata = `ADC_RST_BYTE;
        if (req.rd)
        begin
            unique case (req.addr)
                `ADC_OFS_DAC2_LOW: next_rdata = dac_low;
                `ADC_OFS_DAC2_CTRL: next_rdata = dac_ctrl;
                `ADC_OFS_IRQ:
                begin
                    next_rdata[`ADC_BIT_DERR] = derr;
                    next_rdata[`ADC_BIT_SERR] = serr;
                    next_rdata[`ADC_BIT_ETYPE] = etype;
                    next_rdata[`ADC_BIT_DEN] = den;
                    next_rdata[`ADC_BIT_SEN] = sen;
                    next_rdata[`ADC_BIT_LOOP] = loopen;
                end
                `ADC_OFS_REV: next_rdata = REVISION;
                default: next_rdata = `ADC_RST_BYTE;
            endcase
        end
        else
            next_rdata = rdata;
    end

    // registers only
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_low <= `ADC_RST_BYTE;
            dac_ctrl <= `ADC_RST_BYTE;
            derr <= 1'b0;
            serr <= 1'b0;
            etype <= 1'b0;
            den <= 1'b0;
            sen <= 1'b0;
            loopen <= 1'b0;
            rdata <= `ADC_RST_BYTE;
        end
        else
        begin
            dac_low <= next_dac_low;
            dac_ctrl <= next_dac_ctrl;
            derr <= next_derr;
            serr <= next_serr;
            etype <= next_etype;
            den <= next_den;
            sen <= next_sen;
            loopen <= next_loopen;
            rdata <= next_rdata;
        end
    end

    // analog controls; straight binary word keeps the current monotonic
    assign aux2.level = {dac_ctrl[`ADC_MSB_HI:0], dac_low};
    assign aux2.neg_leg = dac_ctrl[`ADC_BIT_LEG];
    assign aux2.sink = dac_ctrl[`ADC_BIT_DIR];
    assign aux2.power_down = dac_ctrl[`ADC_BIT_PD];
    assign aux2_positive_output = ~dac_ctrl[`ADC_BIT_LEG] & ~dac_ctrl[`ADC_BIT_PD];
    assign aux2_negative_output = dac_ctrl[`ADC_BIT_LEG] & ~dac_ctrl[`ADC_BIT_PD];
    assign sync_in_path = loopen ? sync_out : sync_in_pin;
    assign irq = (derr & den) | (serr & sen);

    sequence seq_err_pulse;
        data_timing_err;
    endsequence

    flag_sets_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_err_pulse |=> derr) else $error("data flag not set");
    flag_clears_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (rd_irq && !data_timing_err) |=> !derr) else $error("data flag not cleared");
    sync_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sync_timing_err |=> serr) else $error("sync flag not set");
    sync_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (serr && !rd_irq) |=> serr) else $error("sync flag lost");
    err_type_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        data_timing_err |=> etype == $past(data_err_is_setup)) else $error("wrong error type");
    irq_data_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (derr && den) |-> irq) else $error("irq missing");
    irq_mask_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!(derr && den) && !(serr && sen)) |-> !irq) else $error("irq unmasked");
    rev_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (req.rd && req.addr == `ADC_OFS_REV) |=> rdata == REVISION) else $error("bad revision");
    level_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (req.wr && req.addr == `ADC_OFS_DAC2_LOW) |=> aux2.level[7:0] == $past(req.wdata))
        else $error("level low not written");
    loop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        loopen |-> sync_in_path == sync_out) else $error("loopback broken");
    pd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        aux2.power_down |-> !aux2_positive_output && !aux2_negative_output) else $error("not powered down");
    rsv_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (req.rd && req.addr >= `ADC_OFS_RSV_FIRST && req.addr <= `ADC_OFS_RSV_LAST) |=> rdata == `ADC_RST_BYTE)
        else $error("reserved not zero");

    // request shapes shared by the checks below
    sequence seq_ctrl_wr;
        req.wr && req.addr == `ADC_OFS_DAC2_CTRL;
    endsequence

    sequence seq_irq_wr;
        req.wr && req.addr == `ADC_OFS_IRQ;
    endsequence

    // clearing read that meets a fresh error; the error must survive
    sequence seq_read_race;
        rd_irq && data_timing_err;
    endsequence

    // control byte lands in level bits and analog controls one cycle on
    level_hi_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_ctrl_wr |=> aux2.level[9:8] == $past(req.wdata[`ADC_MSB_HI:0]))
        else $error("level high not written");
    dir_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_ctrl_wr |=> aux2.sink == $past(req.wdata[`ADC_BIT_DIR]))
        else $error("direction not written");
    pd_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_ctrl_wr |=> aux2.power_down == $past(req.wdata[`ADC_BIT_PD]))
        else $error("power-down not written");

    // one leg at most; a live converter always drives the selected leg
    legs_excl_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !(aux2_positive_output && aux2_negative_output))
        else $error("both legs active");
    pos_leg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!aux2.neg_leg && !aux2.power_down) |-> aux2_positive_output)
        else $error("positive leg idle");
    neg_leg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (aux2.neg_leg && !aux2.power_down) |-> aux2_negative_output)
        else $error("negative leg idle");

    // enables and loopback follow the written bits
    den_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_irq_wr |=> den == $past(req.wdata[`ADC_BIT_DEN]))
        else $error("data enable not written");
    sen_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_irq_wr |=> sen == $past(req.wdata[`ADC_BIT_SEN]))
        else $error("sync enable not written");
    loop_wr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_irq_wr |=> loopen == $past(req.wdata[`ADC_BIT_LOOP]))
        else $error("loopback not written");

    // flags: set wins, nothing but a read or reset clears, read shows the old view
    race_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        seq_read_race |=> derr)
        else $error("error lost to read");
    data_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (derr && !rd_irq) |=> derr)
        else $error("data flag lost");
    sync_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (rd_irq && !sync_timing_err) |=> !serr)
        else $error("sync flag not cleared");
    flag_view_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_irq |=> rdata[`ADC_BIT_DERR] == $past(derr))
        else $error("data flag not shown");
    type_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !data_timing_err |=> $stable(etype))
        else $error("error type drifted");

    // interrupt and sync routing
    irq_sync_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (serr && sen) |-> irq)
        else $error("sync irq missing");
    pin_path_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !loopen |-> sync_in_path == sync_in_pin)
        else $error("pin not routed");

    // read data holds between reads so software may sample late
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !req.rd |=> $stable(rdata))
        else $error("read data moved");
endmodule // adc_regs

// File: dv/adc_regs_tb.sv
// bench for the aux converter 2 and timing-error register slice
// assumes adc_pkg and adc_regs are compiled first; inputs move on falling edges
`timescale 1ns/10ps
module adc_regs_tb
    import adc_pkg::*;
;
    localparam logic [7:0] REV = 8'h5C; // arbitrary value
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    adc_req_t req = '0;
    logic [7:0] rdata;
    logic derr = 1'b0;
    logic setup = 1'b0;
    logic serr = 1'b0;
    logic s_out = 1'b0;
    logic s_pin = 1'b0;
    logic s_path;
    adc_aux_t aux2;
    logic pos;
    logic neg;
    logic irq;
    int errors = 0;
    int num_checks = 0;

    adc_regs #(
        .REVISION(REV)
    ) DUT (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .req(req),
        .rdata(rdata),
        .data_timing_err(derr),
        .data_err_is_setup(setup),
        .sync_timing_err(serr),
        .sync_out(s_out),
        .sync_in_pin(s_pin),
        .sync_in_path(s_path),
        .aux2(aux2),
        .aux2_positive_output(pos),
        .aux2_negative_output(neg),
        .irq(irq)
    );

    always #25 clk_sys = ~clk_sys;

    // one compare; unknowns count as mismatches
    task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one strobe cycle then an idle cycle, so no signal is set twice at one edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req = '0;
        @(negedge clk_sys);
    endtask

    // read data is registered, so it is taken a full cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        req = '0;
        @(negedge clk_sys);
        d = rdata;
    endtask

    // one-cycle error pulse on the data or the sync detector
    task automatic pulse(input logic is_data, input logic is_setup);
        derr = is_data;
        serr = ~is_data;
        setup = is_setup;
        @(negedge clk_sys);
        derr = 1'b0;
        serr = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic t_reset;
        logic [7:0] d;
        chk("legs reset", {pos, neg}, 2'b10);
        chk("aux2 reset", aux2, 13'h0000);
        rd(5'h11, d);
        chk("low reset", d, 8'h00);
        rd(5'h12, d);
        chk("ctrl reset", d, 8'h00);
        rd(5'h19, d);
        chk("irq reg reset", d, 8'h00);
        chk("irq reset", irq, 1'b0);
        rd(5'h1F, d);
        chk("revision", d, REV);
        wr(5'h1F, 8'h00);
        rd(5'h1F, d);
        chk("revision kept", d, REV);
    endtask

    task automatic t_aux;
        logic [7:0] d;
        wr(5'h11, 8'hFF);
        wr(5'h12, 8'hE3);
        chk("aux2 all set", aux2, {10'h3FF, 3'b111});
        chk("legs off", {pos, neg}, 2'b00);
        wr(5'h12, 8'h81);
        chk("aux2 neg leg", aux2, {10'h1FF, 3'b100});
        chk("legs neg", {pos, neg}, 2'b01);
        wr(5'h11, 8'h00);
        wr(5'h12, 8'h02);
        chk("level up", aux2.level > 10'h1FF, 1'b1);
        chk("aux2 pos leg", aux2, {10'h200, 3'b000});
        chk("legs pos", {pos, neg}, 2'b10);
        rd(5'h12, d);
        chk("ctrl back", d, 8'h02);
    endtask

    // sync levels set apart from the pin so the route is visible
    task automatic t_flags;
        logic [7:0] d;
        s_out = 1'b1;
        wr(5'h19, 8'h0D);
        chk("loop on", s_path, 1'b1);
        pulse(1'b1, 1'b1);
        chk("data irq", irq, 1'b1);
        rd(5'h19, d);
        chk("setup flag", d, 8'h9D);
        chk("irq after read", irq, 1'b0);
        rd(5'h19, d);
        chk("flag cleared", d & 8'hEF, 8'h0D);
        pulse(1'b1, 1'b0);
        rd(5'h19, d);
        chk("hold flag", d, 8'h8D);
        s_out = 1'b0;
        s_pin = 1'b1;
        wr(5'h19, 8'h00);
        chk("loop off", s_path, 1'b1);
        pulse(1'b0, 1'b0);
        chk("sync masked", irq, 1'b0);
        wr(5'h19, 8'h04);
        chk("sync irq", irq, 1'b1);
        rd(5'h19, d);
        chk("sync flag", d & 8'hEF, 8'h44);
        rd(5'h19, d);
        chk("sync cleared", d & 8'hEF, 8'h04);
        wr(5'h19, 8'hC0);
        rd(5'h19, d);
        chk("flags not writable", d & 8'hC0, 8'h00);
    endtask

    // errors that meet the clearing read in one cycle must stay latched
    task automatic t_race;
        logic [7:0] d;
        derr = 1'b1;
        serr = 1'b1;
        setup = 1'b1;
        req = '{wr: 1'b0, rd: 1'b1, addr: 5'h19, wdata: 8'h00};
        @(negedge clk_sys);
        derr = 1'b0;
        serr = 1'b0;
        req = '0;
        @(negedge clk_sys);
        chk("race old view", rdata & 8'hC0, 8'h00);
        rd(5'h19, d);
        chk("data set wins", d & 8'h90, 8'h90);
        chk("sync set wins", d & 8'h40, 8'h40);
        rd(5'h19, d);
        chk("race cleared", d & 8'hC0, 8'h00);
    endtask

    task automatic t_resv;
        logic [7:0] d;
        for (int a = 8'h13; a <= 8'h18; a++)
        begin
            wr(5'(a), 8'hFF);
            rd(5'(a), d);
            chk("reserved", d, 8'h00);
        end
    endtask

    // reset in mid-run with state and a pending interrupt
    task automatic t_midreset;
        logic [7:0] d;
        wr(5'h12, 8'h23);
        wr(5'h19, 8'h08);
        pulse(1'b1, 1'b1);
        chk("irq before reset", irq, 1'b1);
        rd(5'h12, d);
        chk("ctrl before reset", d, 8'h23);
        arst_n = 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        chk("rdata after reset", rdata, 8'h00);
        chk("aux2 after reset", aux2, 13'h0000);
        chk("legs after reset", {pos, neg}, 2'b10);
        chk("irq after reset", irq, 1'b0);
        rd(5'h19, d);
        chk("flags after reset", d, 8'h00);
        rd(5'h12, d);
        chk("ctrl after reset", d, 8'h00);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // scenarios in order, then the single verdict
    initial
    begin
        repeat (6) @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset();
        t_aux();
        t_flags();
        t_race();
        t_resv();
        t_midreset();
        summarize();
    end
endmodule // adc_regs_tb
